// file: src/msx_exec.sv
// Purpose: Execution slice for subtract, special-page moves, halt and nibble swap, behind Avalon-MM
// Assumes: One clock core_clk at 100 MHz, synchronous active-low reset
// Notes:   A command word written to the command register with byte lanes 0 and 1 executes at the write's accepting edge, unless halted
// Notes on behaviour
// - Register borrow-subtract adds register, inverted accumulator and carry, index 0..63, one cycle.
// - Destination bit 0 writes accumulator, bit 1 writes back the addressed register.
// - Immediate borrow-subtract adds immediate, inverted accumulator and carry into accumulator.
// - Register subtract forms register minus accumulator, updates zero, half and carry flags.
// - Immediate subtract forms immediate minus accumulator, always into accumulator, updates flags.
// - Special-page store copies accumulator into page register 0..15, flags unchanged.
// - Special-page load copies page register 0..15 into accumulator, flags unchanged.
// - Halt clears watchdog counter and its prescaler to zero.
// - Halt sets timeout flag, clears power-down flag and enters halt mode, all at the same edge.
// - Nibble swap exchanges register halves, routed by destination bit.
`timescale 1ns/10ps
`include "msx_map.svh"
module msx_exec
    import msx_pkg::*;
#(
    parameter int REG_DEPTH   = 64,
    parameter int SPAGE_DEPTH = 16,
    parameter int WDT_W       = 8,
    parameter int PRE_W       = 8
) (
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        wake_req,
    output logic             halt_mode
);
    localparam int RI_W = $clog2(REG_DEPTH);
    localparam int SI_W = $clog2(SPAGE_DEPTH);

    // Indices are plain bit slices of the operand, so depths must be powers of two
    if (REG_DEPTH < 2 || REG_DEPTH > 64 || SPAGE_DEPTH < 2 || SPAGE_DEPTH > 16 ||
        (REG_DEPTH & (REG_DEPTH - 1)) != 0 || (SPAGE_DEPTH & (SPAGE_DEPTH - 1)) != 0 ||
        WDT_W < 1 || WDT_W > 16 || PRE_W < 1 || PRE_W > 16) begin : g_bad_param
        $error("msx_exec: unsupported parameter value");
    end

    logic [7:0]       regfile_r [REG_DEPTH];
    logic [7:0]       spage_r   [SPAGE_DEPTH];
    logic [7:0]       acc_r;
    logic             carry_r;
    logic             half_r;
    logic             zero_r;
    logic             timeout_n_r;
    logic             powerdown_n_r;
    logic             halt_r;
    logic [WDT_W-1:0] wdt_r;
    logic [PRE_W-1:0] pre_r;
    logic             ack_r;
    logic [31:0]      rdata_r;
    logic             req;
    logic             wr_fire;
    logic             cmd_fire;
    msx_cmd_s         cmd;
    msx_alu_s         alu_res;
    logic [RI_W-1:0]  ridx;
    logic [SI_W-1:0]  sidx;
    logic [7:0]       operand_a;
    logic             reg_form;
    logic             arith;

    // Word index into a window, or all ones when outside it
    function automatic logic [6:0] win_idx(input logic [9:0] addr, input logic [9:0] base, input int depth);
        logic [9:0] off;
        off = addr - base;
        win_idx = 7'h7f;
        if (addr >= base && off[9:2] < 8'(depth) && off[1:0] == 2'b00) begin
            win_idx = off[8:2];
        end
    endfunction

    // One wait cycle per access: read data is fetched on the first edge, presented on the second
    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_r;
    assign avs_readdata    = rdata_r;
    assign wr_fire         = avs_write & ack_r;
    assign cmd             = msx_cmd_s'(avs_writedata[15:0]);
    assign cmd_fire        = wr_fire && avs_address == `MSX_OFS_CMD && avs_byteenable[1:0] == 2'b11 && !halt_r;
    assign ridx            = cmd.operand[RI_W-1:0];
    assign sidx            = cmd.operand[SI_W-1:0];
    assign reg_form        = cmd.op == sub_borrow_reg_op || cmd.op == sub_reg_op || cmd.op == nibble_swap_op;
    assign arith           = cmd.op inside {sub_borrow_reg_op, sub_borrow_imm_op, sub_reg_op, sub_imm_op};
    assign operand_a       = reg_form ? regfile_r[ridx] : cmd.operand;
    assign halt_mode       = halt_r;

    msx_alu u_alu (
        .operand     (operand_a),
        .accumulator (acc_r),
        .carry_flag  (carry_r),
        .op          (cmd.op),
        .res         (alu_res)
    );

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            rdata_r <= 32'h0000_0000;
        end else if (avs_read && !ack_r) begin
            rdata_r <= 32'h0000_0000;
            if (avs_address == `MSX_OFS_ACC) begin
                rdata_r[7:0] <= acc_r;
            end else if (avs_address == `MSX_OFS_STATUS) begin
                rdata_r[`MSX_ST_CARRY] <= carry_r;
                rdata_r[`MSX_ST_HALF]  <= half_r;
                rdata_r[`MSX_ST_ZERO]  <= zero_r;
                rdata_r[`MSX_ST_PD_N]  <= powerdown_n_r;
                rdata_r[`MSX_ST_TO_N]  <= timeout_n_r;
                rdata_r[`MSX_ST_HALT]  <= halt_r;
            end else if (avs_address == `MSX_OFS_WDT) begin
                rdata_r[WDT_W-1:0] <= wdt_r;
                rdata_r[`MSX_WDT_PRE_LSB +: PRE_W] <= pre_r;
            end else if (win_idx(avs_address, `MSX_OFS_REGF_BASE, REG_DEPTH) != 7'h7f) begin
                rdata_r[7:0] <= regfile_r[RI_W'(win_idx(avs_address, `MSX_OFS_REGF_BASE, REG_DEPTH))];
            end else if (win_idx(avs_address, `MSX_OFS_SPAGE_BASE, SPAGE_DEPTH) != 7'h7f) begin
                rdata_r[7:0] <= spage_r[SI_W'(win_idx(avs_address, `MSX_OFS_SPAGE_BASE, SPAGE_DEPTH))];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            acc_r <= `MSX_RST_ACC;
        end else if (cmd_fire) begin
            if ((arith || cmd.op == nibble_swap_op) && !(reg_form && cmd.dest)) begin
                acc_r <= alu_res.value;
            end else if (cmd.op == special_page_load_op) begin
                acc_r <= spage_r[sidx];
            end
        end else if (wr_fire && avs_address == `MSX_OFS_ACC && avs_byteenable[0]) begin
            acc_r <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            for (int i = 0; i < REG_DEPTH; i++) begin
                regfile_r[i] <= `MSX_RST_DATA;
            end
        end else if (cmd_fire && reg_form && cmd.dest) begin
            regfile_r[ridx] <= alu_res.value;
        end else if (wr_fire && avs_byteenable[0] && win_idx(avs_address, `MSX_OFS_REGF_BASE, REG_DEPTH) != 7'h7f) begin
            regfile_r[RI_W'(win_idx(avs_address, `MSX_OFS_REGF_BASE, REG_DEPTH))] <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            for (int i = 0; i < SPAGE_DEPTH; i++) begin
                spage_r[i] <= `MSX_RST_DATA;
            end
        end else if (cmd_fire && cmd.op == special_page_store_op) begin
            spage_r[sidx] <= acc_r;
        end else if (wr_fire && avs_byteenable[0] && win_idx(avs_address, `MSX_OFS_SPAGE_BASE, SPAGE_DEPTH) != 7'h7f) begin
            spage_r[SI_W'(win_idx(avs_address, `MSX_OFS_SPAGE_BASE, SPAGE_DEPTH))] <= avs_writedata[7:0];
        end
    end

    // Arithmetic flags: page moves and swap leave them alone
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            carry_r <= `MSX_RST_FLAG;
            half_r  <= `MSX_RST_FLAG;
            zero_r  <= `MSX_RST_FLAG;
        end else if (cmd_fire && arith) begin
            carry_r <= alu_res.carry;
            half_r  <= alu_res.half_carry;
            zero_r  <= alu_res.zero;
        end else if (wr_fire && avs_address == `MSX_OFS_STATUS && avs_byteenable[0]) begin
            carry_r <= avs_writedata[`MSX_ST_CARRY];
            half_r  <= avs_writedata[`MSX_ST_HALF];
            zero_r  <= avs_writedata[`MSX_ST_ZERO];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            timeout_n_r   <= `MSX_RST_FLAG_N;
            powerdown_n_r <= `MSX_RST_FLAG_N;
        end else if (cmd_fire && cmd.op == halt_op) begin
            timeout_n_r   <= `MSX_HALT_TO_N;
            powerdown_n_r <= `MSX_HALT_PD_N;
        end else if (wr_fire && avs_address == `MSX_OFS_STATUS && avs_byteenable[0]) begin
            timeout_n_r   <= avs_writedata[`MSX_ST_TO_N];
            powerdown_n_r <= avs_writedata[`MSX_ST_PD_N];
        end
    end

    // Halt wins over a wake in the same cycle so the halt is never lost
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            halt_r <= 1'b0;
        end else if (cmd_fire && cmd.op == halt_op) begin
            halt_r <= 1'b1;
        end else if (wake_req) begin
            halt_r <= 1'b0;
        end
    end

    // Stand-in timebase; it stops while halted and only the clear matters here
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            wdt_r <= '0;
            pre_r <= '0;
        end else if (cmd_fire && cmd.op == halt_op) begin
            wdt_r <= '0;
            pre_r <= '0;
        end else if (!halt_r) begin
            pre_r <= pre_r + PRE_W'(1);
            if (&pre_r) begin
                wdt_r <= wdt_r + WDT_W'(1);
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    a_sbc_reg_acc: assert property (cmd_fire && cmd.op == sub_borrow_reg_op && !cmd.dest |=>
        acc_r == 8'($past(operand_a) + ~$past(acc_r) + {7'h00, $past(carry_r)}))
        else $error("register borrow-subtract result wrong");
    a_dest_reg_keep: assert property (cmd_fire && reg_form && cmd.dest |=> acc_r == $past(acc_r))
        else $error("register destination changed accumulator");
    a_sbc_imm_acc: assert property (cmd_fire && cmd.op == sub_borrow_imm_op |=>
        acc_r == 8'($past(cmd.operand) + ~$past(acc_r) + {7'h00, $past(carry_r)}))
        else $error("immediate borrow-subtract result wrong");
    a_sub_reg_acc: assert property (cmd_fire && cmd.op == sub_reg_op && !cmd.dest |=>
        acc_r == 8'($past(operand_a) - $past(acc_r)))
        else $error("register subtract result wrong");
    a_sub_imm_acc: assert property (cmd_fire && cmd.op == sub_imm_op |=>
        acc_r == 8'($past(cmd.operand) - $past(acc_r)))
        else $error("immediate subtract result wrong");
    a_zero_follows: assert property (cmd_fire && arith && !(reg_form && cmd.dest) |=> zero_r == (acc_r == 8'h00))
        else $error("zero flag disagrees with result");
    a_spage_store: assert property (cmd_fire && cmd.op == special_page_store_op |=>
        spage_r[$past(sidx)] == $past(acc_r) && $stable({carry_r, half_r, zero_r}))
        else $error("special-page store wrong");
    a_spage_load: assert property (cmd_fire && cmd.op == special_page_load_op |=>
        acc_r == $past(spage_r[sidx]) && $stable({carry_r, half_r, zero_r}))
        else $error("special-page load wrong");
    a_halt_clears: assert property (cmd_fire && cmd.op == halt_op |=> wdt_r == '0 && pre_r == '0)
        else $error("halt did not clear watchdog");
    a_halt_flags: assert property (cmd_fire && cmd.op == halt_op |=>
        timeout_n_r && !powerdown_n_r && halt_mode && $past(!halt_mode))
        else $error("halt flags or mode wrong");
    a_swap_route: assert property (cmd_fire && cmd.op == nibble_swap_op && cmd.dest |=>
        regfile_r[$past(ridx)] == {$past(operand_a[3:0]), $past(operand_a[7:4])})
        else $error("nibble swap wrong");
    a_carry_borrow: assert property (cmd_fire && cmd.op inside {sub_reg_op, sub_imm_op} |=>
        carry_r == ($past(operand_a) >= $past(acc_r)) && half_r == ($past(operand_a[3:0]) >= $past(acc_r[3:0])))
        else $error("carry or half carry wrong");

    c_sbc_reg_back: cover property (cmd_fire && cmd.op == sub_borrow_reg_op && cmd.dest);
    c_halt_wake: cover property (cmd_fire && cmd.op == halt_op ##[1:1000] wake_req);
    c_store_load: cover property (cmd_fire && cmd.op == special_page_store_op ##[2:10] cmd_fire && cmd.op == special_page_load_op);
endmodule

// file: src/msx_map.svh
// Purpose: Register offsets, field positions and reset values of the subtract/special-page/halt slice
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, one aligned word per register
// Notes:   Definitions only
`ifndef MSX_MAP_SVH
`define MSX_MAP_SVH

`define MSX_OFS_CMD        10'h000
`define MSX_OFS_ACC        10'h004
`define MSX_OFS_STATUS     10'h008
`define MSX_OFS_WDT        10'h00c
`define MSX_OFS_REGF_BASE  10'h100
`define MSX_OFS_SPAGE_BASE 10'h200

`define MSX_ST_CARRY       0
`define MSX_ST_HALF        1
`define MSX_ST_ZERO        2
`define MSX_ST_PD_N        3
`define MSX_ST_TO_N        4
`define MSX_ST_HALT        5
`define MSX_WDT_PRE_LSB    16

`define MSX_RST_ACC        8'h00
`define MSX_RST_DATA       8'h00
`define MSX_RST_FLAG       1'b0
`define MSX_RST_FLAG_N     1'b1
`define MSX_HALT_TO_N      1'b1
`define MSX_HALT_PD_N      1'b0
`define MSX_BORROW_CIN     1'b1
`define MSX_NIB_LO_MSB     3
`define MSX_NIB_HI_LSB     4

`endif

// file: src/msx_pkg.sv
// Purpose: Types shared by the execution slice and its arithmetic unit
// Assumes: 8-bit data path
// Notes:   Command word layout is carried by msx_cmd_s
package msx_pkg;

    typedef enum logic [2:0] {
        sub_borrow_reg_op     = 3'h0,
        sub_borrow_imm_op     = 3'h1,
        sub_reg_op            = 3'h2,
        sub_imm_op            = 3'h3,
        special_page_store_op = 3'h4,
        special_page_load_op  = 3'h5,
        halt_op               = 3'h6,
        nibble_swap_op        = 3'h7
    } msx_op_e;

    typedef struct packed {
        logic [7:0] operand;
        logic [3:0] spare;
        logic       dest;
        msx_op_e    op;
    } msx_cmd_s;

    typedef struct packed {
        logic [7:0] value;
        logic       zero;
        logic       half_carry;
        logic       carry;
    } msx_alu_s;

endpackage

// file: src/msx_alu.sv
// Purpose: Combinational adder for the subtract forms and the nibble swap
// Assumes: Subtraction done as operand plus inverted accumulator plus carry-in
// Notes:   Flags are only meaningful for the four subtract forms
`timescale 1ns/10ps
`include "msx_map.svh"
module msx_alu
    import msx_pkg::*;
(
    input  wire logic [7:0] operand,
    input  wire logic [7:0] accumulator,
    input  wire logic       carry_flag,
    input  wire msx_op_e    op,
    output msx_alu_s        res
);
    logic       cin;
    logic [4:0] low_sum;
    logic [8:0] full_sum;

    always_comb begin
        // Borrow-using forms feed the carry flag, plain subtract adds one
        cin = ((op == sub_borrow_reg_op) || (op == sub_borrow_imm_op)) ? carry_flag : `MSX_BORROW_CIN;
        low_sum  = {1'b0, operand[3:0]} + {1'b0, ~accumulator[3:0]} + {4'h0, cin};
        full_sum = {1'b0, operand} + {1'b0, ~accumulator} + {8'h00, cin};
        res.value      = full_sum[7:0];
        res.carry      = full_sum[8];
        res.half_carry = low_sum[4];
        res.zero       = (full_sum[7:0] == 8'h00);
        if (op == nibble_swap_op) begin
            res.value = {operand[`MSX_NIB_LO_MSB:0], operand[7:`MSX_NIB_HI_LSB]};
        end
    end
endmodule

// file: tb/test_msx_exec.sv
// Purpose: Self-checking bench for the execution slice, driven over Avalon-MM
// Assumes: One access at a time; the slave answers after its own wait state
// Notes:   Expected results come from a local adder model, never from the design
`timescale 1ns/10ps
`include "msx_map.svh"
module test_msx_exec
    import msx_pkg::*;
;
    logic        core_clk;
    logic        reset_n;
    logic [9:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        wake_req;
    logic        halt_mode;
    logic [31:0] rd;
    int          error_cnt;
    int          cmp_count;
    int          cyc;
    // Fields: [30:28] op, [25] dest, [24] carry in, [21:16] index, [15:8] operand, [7:0] accumulator
    logic [31:0] vec [9] = '{32'h0_2_3f_05_06, 32'h0_3_00_05_06, 32'h0_0_01_06_05, 32'h0_1_02_06_05,
                             32'h1_0_00_05_06, 32'h1_3_00_06_05, 32'h2_2_20_05_06, 32'h2_0_21_10_01,
                             32'h3_2_00_00_00};

    msx_exec dut_u (
        .core_clk        (core_clk),
        .reset_n         (reset_n),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .wake_req        (wake_req),
        .halt_mode       (halt_mode)
    );

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // A hang in the bus handshake ends here instead of running forever
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            summarize();
        end
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Request held until the rising edge that sees waitrequest low; data taken at that edge
    task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d, input logic [3:0] be);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_read       <= ~wr;
        avs_write      <= wr;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask

    task automatic rchk(input string nm, input logic [9:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hf);
        check(nm, rd, exp);
    endtask

    task automatic cmd(input msx_op_e op, input logic d, input logic [7:0] o);
        wr(`MSX_OFS_CMD, {16'h0, o, 4'h0, d, op});
    endtask

    function automatic msx_alu_s sub_exp(input logic [7:0] a, input logic [7:0] b, input logic ci);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, a} + {1'b0, ~b} + {8'h0, ci};
        h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, ci};
        return '{value: s[7:0], zero: (s[7:0] == 8'h00), half_carry: h[4], carry: s[8]};
    endfunction

    initial begin
        msx_op_e    op;
        logic       dst;
        logic       cin;
        logic       rop;
        logic [5:0] idx;
        logic [7:0] opnd;
        logic [7:0] av;
        logic [9:0] ra;
        msx_alu_s   e;
        reset_n = 1'b0;
        avs_address = 10'h000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        wake_req = 1'b0;
        error_cnt = 0;
        cmp_count = 0;
        cyc = 0;
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);

        rchk("acc reset", `MSX_OFS_ACC, 32'h00);
        rchk("status reset", `MSX_OFS_STATUS, 32'h18);
        rchk("reg63 reset", 10'h1fc, 32'h00);
        rchk("page15 reset", 10'h23c, 32'h00);
        $display("Test reset values done");

        for (int i = 0; i < 9; i++) begin
            op   = msx_op_e'(vec[i][30:28]);
            dst  = vec[i][25];
            cin  = vec[i][24];
            idx  = vec[i][21:16];
            opnd = vec[i][15:8];
            av   = vec[i][7:0];
            rop  = (op == sub_borrow_reg_op) || (op == sub_reg_op);
            ra   = `MSX_OFS_REGF_BASE + {2'b00, idx, 2'b00};
            wr(`MSX_OFS_STATUS, 32'h18 | {31'h0, cin});
            wr(`MSX_OFS_ACC, {24'h0, av});
            if (rop) begin
                wr(ra, {24'h0, opnd});
            end
            cmd(op, dst, rop ? {2'b00, idx} : opnd);
            // Plain subtract forms ignore the stored carry and add one
            e = sub_exp(opnd, av, (op == sub_borrow_reg_op || op == sub_borrow_imm_op) ? cin : `MSX_BORROW_CIN);
            rchk("acc after sub", `MSX_OFS_ACC, {24'h0, (rop && dst) ? av : e.value});
            if (rop) begin
                rchk("reg after sub", ra, {24'h0, dst ? e.value : opnd});
            end
            rchk("flags after sub", `MSX_OFS_STATUS, {29'h3, e.zero, e.half_carry, e.carry});
        end
        $display("Test subtract forms done");

        wr(`MSX_OFS_STATUS, 32'h1d);
        rchk("status preset", `MSX_OFS_STATUS, 32'h1d);
        wr(`MSX_OFS_ACC, 32'haa);
        cmd(special_page_store_op, 1'b0, 8'h0f);
        rchk("page15 store", 10'h23c, 32'haa);
        wr(`MSX_OFS_SPAGE_BASE, 32'h55);
        cmd(special_page_load_op, 1'b0, 8'h00);
        rchk("acc page load", `MSX_OFS_ACC, 32'h55);
        rchk("flags page moves", `MSX_OFS_STATUS, 32'h1d);
        $display("Test special page done");

        wr(10'h128, 32'ha5);
        cmd(nibble_swap_op, 1'b1, 8'h0a);
        rchk("swap to reg", 10'h128, 32'h5a);
        cmd(nibble_swap_op, 1'b0, 8'h0a);
        rchk("swap to acc", `MSX_OFS_ACC, 32'ha5);
        rchk("reg kept", 10'h128, 32'h5a);
        $display("Test nibble swap done");

        cmd(sub_imm_op, 1'b0, 8'h77);
        wr(`MSX_OFS_STATUS, 32'h08);
        bus(1'b1, `MSX_OFS_CMD, 32'h7703, 4'h1);
        // 0x77 minus 0xa5 left 0xd2; a partial command word must not run again
        rchk("partial cmd ignored", `MSX_OFS_ACC, 32'hd2);
        rchk("unmapped read", 10'h3fc, 32'h0);
        repeat (40) @(posedge core_clk);
        cmd(halt_op, 1'b0, 8'h00);
        check("halt mode", {31'h0, halt_mode}, 32'h1);
        rchk("status halted", `MSX_OFS_STATUS, 32'h30);
        rchk("watchdog cleared", `MSX_OFS_WDT, 32'h0);
        repeat (300) @(posedge core_clk);
        rchk("watchdog frozen", `MSX_OFS_WDT, 32'h0);
        cmd(sub_imm_op, 1'b0, 8'h44);
        rchk("cmd in halt ignored", `MSX_OFS_ACC, 32'hd2);
        wake_req <= 1'b1;
        @(posedge core_clk);
        wake_req <= 1'b0;
        @(posedge core_clk);
        check("woken", {31'h0, halt_mode}, 32'h0);
        rchk("status woken", `MSX_OFS_STATUS, 32'h10);
        $display("Test halt and wake done");
        summarize();
    end
endmodule
